/* core/wca_cfg.svh */
// offsets, field positions, reset values and codes of the alert block
`ifndef WCA_CFG_SVH
`define WCA_CFG_SVH

// register offsets on the plain register port
`define WCA_OFF_TRIG 8'h03
`define WCA_OFF_LOW 8'h0C
`define WCA_OFF_HIGH 8'h0E
`define WCA_OFF_COUNT 8'h36
`define WCA_OFF_HYS0 8'h40
`define WCA_OFF_HYS1 8'h41
// sample buffer window: addresses with these top three bits
`define WCA_BUF_SEL 3'h3

// field positions
`define WCA_HYS_MSB 5
`define WCA_HYS_LSB 0
`define WCA_CNT_MSB 7
`define WCA_CNT_LSB 4

// reset values
`define WCA_HYS_RST 6'h00
`define WCA_CNT_RST 4'h0
`define WCA_TRIG_RST 4'h0
`define WCA_FLAGS_RST 2'h0

// channel id codes
`define WCA_CHID_CH0 4'h0
`define WCA_CHID_CH1 4'h1

// run counter ceiling and step
`define WCA_RUN_MAX 5'h10
`define WCA_RUN_ONE 5'h01

`endif

/* core/wca_pkg.sv */
// types shared by the window comparator alert block
package wca_pkg;

    // one conversion result from the converter
    typedef struct packed {
        logic valid;
        logic chan;
        logic [11:0] value;
    } conv_s;

    // programmed thresholds of both channels
    typedef struct packed {
        logic [1:0][11:0] low_th;
        logic [1:0][11:0] high_th;
    } thresh_s;

    // one stored buffer entry
    typedef struct packed {
        logic chan;
        logic [11:0] value;
    } sample_s;

    // whole state of the alert block
    typedef struct packed {
        logic [1:0][5:0] chan_hysteresis;
        logic [3:0] consecutive_event_setting;
        logic [3:0] first_trigger_channel_id;
        logic trig_seen;
        logic [1:0] low_alert_flags;
        logic [1:0] high_alert_flags;
        logic [1:0] low_cmp;
        logic [1:0] high_cmp;
        logic [1:0][4:0] low_run;
        logic [1:0][4:0] high_run;
        logic [15:0][12:0] samples;
        logic [3:0] wr_ptr;
        logic [7:0] rdata;
    } state_s;

endpackage : wca_pkg

/* core/window_alert.sv */
// two-channel window comparator alert, flags, trigger id and sample buffer
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "wca_cfg.svh"

module window_alert
    import wca_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire conv_s conv,
    input wire thresh_s thresholds,
    input wire logic sequence_go_bit,
    input wire logic gen_call_reset,
    input wire logic device_reset,
    output logic alert_out
);

    // registered state and its next value
    state_s q;
    state_s d;

    // comparator with hysteresis; keeps set until past threshold by hys
    function automatic logic cmp_next(
        input logic active,
        input logic high_side,
        input logic [11:0] value,
        input logic [11:0] th,
        input logic [5:0] hys
    );
        logic [12:0] v;
        logic [12:0] t;
        logic [12:0] h;
        v = {1'b0, value};
        t = {1'b0, th};
        h = {7'h00, hys};
        if (high_side)
        begin
            // set at or above, release below th - hys
            cmp_next = active ? (v + h >= t) : (v >= t);
        end
        else
        begin
            // set at or below, release above th + hys
            cmp_next = active ? (v <= t + h) : (v <= t);
        end
    endfunction : cmp_next

    // consecutive hit counter, saturating, zero on a miss
    function automatic logic [4:0] run_next(
        input logic hit,
        input logic [4:0] run
    );
        if (!hit)
        begin
            run_next = 5'h00;
        end
        else if (run == `WCA_RUN_MAX)
        begin
            run_next = run;
        end
        else
        begin
            run_next = run + `WCA_RUN_ONE;
        end
    endfunction : run_next

    // register read decode; unmapped reads give zero
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input state_s s
    );
        sample_s e;
        logic [3:0] idx;
        idx = s.wr_ptr + addr[4:1];
        e = s.samples[idx];
        read_mux = 8'h00;
        if (addr[7:5] == `WCA_BUF_SEL)
        begin
            // newest entry last; even lsb byte, odd chan and msbs
            read_mux = addr[0] ? {3'h0, e.chan, e.value[11:8]}
                               : e.value[7:0];
        end
        else
        begin
            unique case (addr)
                `WCA_OFF_TRIG:
                    read_mux = {s.first_trigger_channel_id, 4'h0};
                `WCA_OFF_LOW:
                    read_mux = {6'h00, s.low_alert_flags};
                `WCA_OFF_HIGH:
                    read_mux = {6'h00, s.high_alert_flags};
                `WCA_OFF_COUNT:
                    read_mux = {s.consecutive_event_setting, 4'h0};
                `WCA_OFF_HYS0:
                    read_mux = {2'h0, s.chan_hysteresis[0]};
                `WCA_OFF_HYS1:
                    read_mux = {2'h0, s.chan_hysteresis[1]};
                default:
                    read_mux = 8'h00;
            endcase
        end
    endfunction : read_mux

    // any latched flag drives the wake line
    assign alert_out = |{q.low_alert_flags, q.high_alert_flags};
    assign reg_rdata = q.rdata;

    // next-state logic
    always_comb
    begin
        logic [1:0] low_clr;
        logic [1:0] high_clr;
        logic [1:0] low_set;
        logic [1:0] high_set;
        logic [4:0] target;
        low_clr = 2'h0;
        high_clr = 2'h0;
        low_set = 2'h0;
        high_set = 2'h0;
        d = q;
        // shared count, field plus one
        target = {1'b0, q.consecutive_event_setting} + `WCA_RUN_ONE;
        if (ce)
        begin
            // read data stand one cycle only
            d.rdata = reg_rd ? read_mux(reg_addr, q) : 8'h00;
            // register writes
            if (reg_wr)
            begin
                unique case (reg_addr)
                    `WCA_OFF_HYS0:
                        d.chan_hysteresis[0] =
                            reg_wdata[`WCA_HYS_MSB:`WCA_HYS_LSB];
                    `WCA_OFF_HYS1:
                        d.chan_hysteresis[1] =
                            reg_wdata[`WCA_HYS_MSB:`WCA_HYS_LSB];
                    `WCA_OFF_COUNT:
                        d.consecutive_event_setting =
                            reg_wdata[`WCA_CNT_MSB:`WCA_CNT_LSB];
                    // write one to clear; FFh clears both flags
                    `WCA_OFF_LOW:
                        low_clr = reg_wdata[1:0];
                    `WCA_OFF_HIGH:
                        high_clr = reg_wdata[1:0];
                    default:
                        low_clr = 2'h0; // unmapped and read-only ignored
                endcase
            end
            // conversion result processing for its channel
            if (conv.valid)
            begin
                for (int c = 0; c < 2; c++)
                begin
                    if (conv.chan == c[0])
                    begin
                        d.low_cmp[c] = cmp_next(q.low_cmp[c], 1'b0,
                            conv.value, thresholds.low_th[c],
                            q.chan_hysteresis[c]);
                        d.high_cmp[c] = cmp_next(q.high_cmp[c], 1'b1,
                            conv.value, thresholds.high_th[c],
                            q.chan_hysteresis[c]);
                        d.low_run[c] = run_next(d.low_cmp[c], q.low_run[c]);
                        d.high_run[c] = run_next(d.high_cmp[c],
                            q.high_run[c]);
                        // alert only after enough consecutive hits
                        low_set[c] = d.low_run[c] >= target;
                        high_set[c] = d.high_run[c] >= target;
                    end
                end
                // buffer fills until an alert is latched
                if (!alert_out)
                begin
                    d.samples[q.wr_ptr] = {conv.chan, conv.value};
                    d.wr_ptr = q.wr_ptr + 4'h1;
                end
            end
            // sequence start clears the trigger record
            if (sequence_go_bit)
            begin
                d.first_trigger_channel_id = `WCA_TRIG_RST;
                d.trig_seen = 1'b0;
            end
            // set wins over clear
            d.low_alert_flags = (q.low_alert_flags & ~low_clr) | low_set;
            d.high_alert_flags = (q.high_alert_flags & ~high_clr) | high_set;
            // first channel to raise alert is kept; looks at the next
            // record so a same-cycle sequence start loses to the set
            if (|{low_set, high_set} && !d.trig_seen)
            begin
                d.first_trigger_channel_id = conv.chan ? `WCA_CHID_CH1
                                                       : `WCA_CHID_CH0;
                d.trig_seen = 1'b1;
            end
            // general call and device reset clear all state
            if (gen_call_reset || device_reset)
            begin
                d = '0;
            end
        end
    end

    // state register, all zero at power-up
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // alert rise always comes with a recorded trigger
    trig_on_alert_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(alert_out) |-> q.trig_seen)
        else $error("alert rose without trigger record");

    // recorded trigger id kept until a sequence start or a reset
    trig_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        q.trig_seen && !sequence_go_bit && !gen_call_reset
            && !device_reset |=> $stable(q.first_trigger_channel_id))
        else $error("trigger id overwritten");

    // sequence start clears the trigger record
    trig_clear_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && sequence_go_bit && !conv.valid |=>
            q.first_trigger_channel_id == 4'h0 && !q.trig_seen)
        else $error("trigger id not cleared by sequence start");

    // write one clears the low flag of channel zero
    low_clear_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && reg_wr && reg_addr == `WCA_OFF_LOW && reg_wdata[0]
            && !conv.valid |=> !q.low_alert_flags[0])
        else $error("low flag not cleared");

    // write zero keeps the high flag of channel one
    high_keep_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && reg_wr && reg_addr == `WCA_OFF_HIGH && !reg_wdata[1]
            && q.high_alert_flags[1] && !gen_call_reset && !device_reset
            |=> q.high_alert_flags[1])
        else $error("high flag lost without clear");

    // reserved low nibble of the count register reads zero
    count_rsv_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && reg_rd && reg_addr == `WCA_OFF_COUNT
            && !gen_call_reset && !device_reset |=>
            reg_rdata[3:0] == 4'h0 && reg_rdata[7:4]
                == $past(q.consecutive_event_setting))
        else $error("count register readback wrong");

    // low flag of channel zero rises only after enough consecutive hits
    low_count_a: assert property (
        @(posedge clk) disable iff (!resetn)
        $rose(q.low_alert_flags[0]) |->
            q.low_run[0] >= {1'b0, $past(q.consecutive_event_setting)}
                + 5'h01)
        else $error("low alert before event count");

    // buffer frozen while alert stands
    buf_freeze_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && conv.valid && alert_out && !gen_call_reset
            && !device_reset |=> $stable(q.wr_ptr))
        else $error("buffer kept filling after alert");

    // miss on channel zero low comparator zeroes its run
    run_restart_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && conv.valid && !conv.chan
            && {1'b0, conv.value} > {1'b0, thresholds.low_th[0]}
                + {7'h00, q.chan_hysteresis[0]}
            |=> q.low_run[0] == 5'h00)
        else $error("run counter not restarted");

    // conversion at or below low threshold alerts at count one
    low_fast_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && conv.valid && !conv.chan
            && conv.value <= thresholds.low_th[0]
            && q.consecutive_event_setting == 4'h0
            && !gen_call_reset && !device_reset
            |=> q.low_alert_flags[0])
        else $error("low alert missing at count one");

    // conversion at or above high threshold alerts at count one
    high_fast_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && conv.valid && conv.chan
            && conv.value >= thresholds.high_th[1]
            && q.consecutive_event_setting == 4'h0
            && !gen_call_reset && !device_reset
            |=> q.high_alert_flags[1])
        else $error("high alert missing at count one");

    // without a write or a reset no latched flag drops
    flag_latch_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !reg_wr && !gen_call_reset && !device_reset |=>
            (q.low_alert_flags & $past(q.low_alert_flags))
                == $past(q.low_alert_flags)
            && (q.high_alert_flags & $past(q.high_alert_flags))
                == $past(q.high_alert_flags))
        else $error("alert flag dropped without clear");

    // reserved upper bits of both flag registers read zero
    flag_rsv_a: assert property (
        @(posedge clk) disable iff (!resetn)
        ce && reg_rd && (reg_addr == `WCA_OFF_LOW
            || reg_addr == `WCA_OFF_HIGH) |=> reg_rdata[7:2] == 6'h00)
        else $error("flag register reserved bits not zero");

endmodule : window_alert

`default_nettype wire

/* sim/host_model.sv */
// host controller model driving the register port of the alert block
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // bus idle from time zero
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write; ones in the data clear flags
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // released data no longer shows the last value
        reg_wdata <= ~d;
        // let the write settle before the caller looks
        #1;
    endtask : wr

    // one-cycle read, data taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : host_model

`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the window comparator alert block
`timescale 1ns/1ps
`default_nettype none
`include "wca_cfg.svh"

module tb_top
    import wca_pkg::*;
;
    logic clk;
    logic resetn;
    logic ce;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    conv_s conv;
    thresh_s thresholds;
    logic sequence_go_bit;
    logic gen_call_reset;
    logic device_reset;
    logic alert_out;
    int bad_count;
    int compares;
    // bench model of the latched flags
    logic [1:0] lo_m;
    logic [1:0] hi_m;
    logic ch;
    logic [11:0] v;
    logic [7:0] rv;

    window_alert i_dut (
        .clk(clk), .resetn(resetn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv(conv),
        .thresholds(thresholds), .sequence_go_bit(sequence_go_bit),
        .gen_call_reset(gen_call_reset), .device_reset(device_reset),
        .alert_out(alert_out)
    );

    host_model i_host (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // compare one value and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // read a register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d, exp);
    endtask : rchk

    // one conversion result, flags settle one cycle later
    task automatic send(input logic c, input logic [11:0] val);
        @(posedge clk);
        conv <= '{1'b1, c, val};
        @(posedge clk);
        conv.valid <= 1'b0;
        #1;
    endtask : send

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // watchdog against a hang
    initial
    begin
        #200000;
        bad_count++;
        final_report();
    end

    // main sequence
    initial
    begin
        resetn = 1'b0;
        ce = 1'b1;
        conv = '0;
        thresholds = '0;
        sequence_go_bit = 1'b0;
        gen_call_reset = 1'b0;
        device_reset = 1'b0;
        bad_count = 0;
        compares = 0;
        void'($urandom(32'h9080));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        // reset values and an unmapped place
        rchk(`WCA_OFF_TRIG, 8'h00);
        rchk(`WCA_OFF_LOW, 8'h00);
        rchk(`WCA_OFF_HIGH, 8'h00);
        rchk(8'h10, 8'h00);
        $display("test reset done");
        // reserved bits read zero
        i_host.wr(`WCA_OFF_COUNT, 8'h2f);
        rchk(`WCA_OFF_COUNT, 8'h20);
        i_host.wr(`WCA_OFF_HYS1, 8'hff);
        rchk(`WCA_OFF_HYS1, 8'h3f);
        rchk(`WCA_OFF_HYS0, 8'h00);
        $display("test fields done");
        // count 3; a rise above low_th plus hysteresis restarts the run
        thresholds <= '{'{12'h064, 12'h064}, '{12'hbb8, 12'hbb8}};
        send(1'b1, 12'h032);
        send(1'b1, 12'h032);
        send(1'b1, 12'h1f4);
        send(1'b1, 12'h032);
        send(1'b1, 12'h032);
        chk({7'h0, alert_out}, 8'h00);
        send(1'b1, 12'h032);
        chk({7'h0, alert_out}, 8'h01);
        rchk(`WCA_OFF_LOW, 8'h02);
        // read data stand for one cycle only
        @(posedge clk);
        #1;
        chk(reg_rdata, 8'h00);
        // later alert of the other channel keeps the first id
        repeat (3) send(1'b0, 12'hfa0);
        rchk(`WCA_OFF_HIGH, 8'h01);
        rchk(`WCA_OFF_TRIG, 8'h10);
        $display("test event count done");
        // write-one-to-clear, zeros leave flags alone
        i_host.wr(`WCA_OFF_LOW, 8'h01);
        rchk(`WCA_OFF_LOW, 8'h02);
        i_host.wr(`WCA_OFF_LOW, 8'h02);
        rchk(`WCA_OFF_LOW, 8'h00);
        chk({7'h0, alert_out}, 8'h01);
        i_host.wr(`WCA_OFF_HIGH, 8'hff);
        chk({7'h0, alert_out}, 8'h00);
        rchk(`WCA_OFF_HIGH, 8'h00);
        $display("test clear done");
        // sequence start clears the id, next alert records anew
        @(posedge clk);
        sequence_go_bit <= 1'b1;
        @(posedge clk);
        sequence_go_bit <= 1'b0;
        rchk(`WCA_OFF_TRIG, 8'h00);
        send(1'b1, 12'h032);
        rchk(`WCA_OFF_TRIG, 8'h10);
        @(posedge clk);
        gen_call_reset <= 1'b1;
        @(posedge clk);
        gen_call_reset <= 1'b0;
        rchk(`WCA_OFF_LOW, 8'h00);
        rchk(`WCA_OFF_TRIG, 8'h00);
        rchk(`WCA_OFF_COUNT, 8'h00);
        $display("test sequence and reset done");
        // random results against the bench model, count one
        thresholds <= '{'{12'h3e8, 12'h3e8}, '{12'hbb8, 12'hbb8}};
        lo_m = 2'b00;
        hi_m = 2'b00;
        for (int i = 0; i < 24; i++)
        begin
            ch = 1'($urandom % 2);
            v = 12'($urandom % 4096);
            send(ch, v);
            if (int'(v) <= 1000)
                lo_m[ch] = 1'b1;
            if (int'(v) >= 3000)
                hi_m[ch] = 1'b1;
            chk({7'h0, alert_out}, {7'h0, |{lo_m, hi_m}});
        end
        rchk(`WCA_OFF_LOW, {6'h00, lo_m});
        rchk(`WCA_OFF_HIGH, {6'h00, hi_m});
        @(posedge clk);
        device_reset <= 1'b1;
        @(posedge clk);
        device_reset <= 1'b0;
        #1;
        chk({7'h0, alert_out}, 8'h00);
        rchk(`WCA_OFF_HIGH, 8'h00);
        $display("test random done");
        // enable low: a hitting result must change nothing
        @(posedge clk);
        ce <= 1'b0;
        send(1'b0, 12'h0c8);
        chk({7'h0, alert_out}, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        // buffer keeps samples up to and with the alerting one
        send(1'b1, 12'h7d0);
        send(1'b0, 12'h1c8);
        send(1'b1, 12'h064);
        rchk(`WCA_OFF_LOW, 8'h03);
        rchk(`WCA_OFF_TRIG, 8'h00);
        rchk(8'h7c, 8'hd0);
        rchk(8'h7d, 8'h17);
        rchk(8'h7e, 8'hc8);
        rchk(8'h7f, 8'h01);
        rchk(8'h60, 8'h00);
        // power-up reset in mid-run clears the flags
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rchk(`WCA_OFF_LOW, 8'h00);
        chk({7'h0, alert_out}, 8'h00);
        $display("test enable, buffer and power-up done");
        final_report();
    end
endmodule : tb_top

`default_nettype wire
